// ---- rtl/amps_consts.svh ----
/*
 Constants of the auto-mute and pin output select block: register
 offsets, field positions, reset values, selector codes, zero-run times.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef AMPS_CONSTS_SVH
`define AMPS_CONSTS_SVH

`define AMPS_ADDR_W 8
`define AMPS_DATA_W 8
`define AMPS_OFF_PIN_DIR 8'h08
`define AMPS_OFF_ZRUN 8'h3b
`define AMPS_OFF_CTL 8'h41
`define AMPS_OFF_DELAY 8'h42
`define AMPS_OFF_SEL2 8'h52
`define AMPS_OFF_PIN_REG 8'h56
`define AMPS_OFF_STAT 8'h60
`define AMPS_OFF_MASK 8'h61
`define AMPS_OFF_LIVE 8'h62

`define AMPS_RST_ZRUN 8'h00
`define AMPS_RST_CTL 3'h4
`define AMPS_RST_DELAY 8'h14
`define AMPS_RST_SEL2 4'h0
`define AMPS_RST_MASK 4'h0

`define AMPS_CTL_A_EN 0
`define AMPS_CTL_B_EN 1
`define AMPS_CTL_JOINT 2
`define AMPS_ZRUN_A_LSB 4
`define AMPS_ZRUN_B_LSB 0
`define AMPS_PIN_BIT 2

`define AMPS_SEL_OFF 4'h0
`define AMPS_SEL_DSP 4'h1
`define AMPS_SEL_REG 4'h2
`define AMPS_SEL_BOTH 4'h3
`define AMPS_SEL_LEFT 4'h4
`define AMPS_SEL_RIGHT 4'h5
`define AMPS_SEL_CLK_BAD 4'h6
`define AMPS_SEL_SDATA 4'h7
`define AMPS_SEL_AN_LEFT 4'h8
`define AMPS_SEL_AN_RIGHT 4'h9
`define AMPS_SEL_LOCK 4'ha
`define AMPS_SEL_CP_CLK 4'hb
`define AMPS_SEL_DAC_CLK 4'hc
`define AMPS_SEL_DSP_CLK4 4'hd
`define AMPS_SEL_UV_HI 4'he
`define AMPS_SEL_UV_LO 4'hf

// zero-run times in microseconds at the nominal frame rate
`define AMPS_FRAME_KHZ 48
`define AMPS_ZRUN_US0 21000
`define AMPS_ZRUN_US1 106000
`define AMPS_ZRUN_US2 213000
`define AMPS_ZRUN_US3 533000
`define AMPS_ZRUN_US4 1070000
`define AMPS_ZRUN_US5 2130000
`define AMPS_ZRUN_US6 5330000
`define AMPS_ZRUN_US7 10660000
`define AMPS_RUN_W 20

`endif

// ---- rtl/amps_pkg.sv ----
/*
 Types of the auto-mute and pin output select block.
 Assumes amps_consts.svh is on the include path.
*/
`include "amps_consts.svh"

package amps_pkg;

  // signals from other clock domains or analog parts
  typedef struct packed {
    logic dsp_pin;
    logic serial_audio_out;
    logic clk_error;
    logic clk_changing;
    logic clk_missing;
    logic pll_lock;
    logic charge_pump_clk;
    logic converter_clk;
    logic dsp_clk_div4;
    logic uv_high;
    logic uv_low;
  } amps_src_type;

  typedef logic [`AMPS_DATA_W-1:0] amps_byte_type;

endpackage

// ---- rtl/amps_top.sv ----
/*
 Auto mute of a stereo playback path with analog mute delay, and the
 source selector of general-purpose pin 2, behind a plain register port.
 Assumes: clk 100 MHz, samples come from logic on clk, the frame clock
 and all other sources arrive asynchronously and are resynchronised.
*/
// Behaviour
// - joint bit clear: each channel mutes on its own zero detection.
// - joint bit set (reset value): mute only when both channels qualify.
// - control bit 1 enables right channel auto mute.
// - control bit 0 enables left channel auto mute.
// - joint with right disabled: left never auto mutes.
// - joint with left disabled: right never auto mutes.
// - auto mute triggers on zero samples, length from zero-run time field.
// - qualify after programmed zero run, 21 ms to 10.66 s at 48 kHz.
// - analog mute follows digital mute after N frame periods, N reset 20.
// - pin codes 0 low, 1 dsp output, 2 software register bit.
// - selected signal reaches pin only when pin set as output.
// - codes 3, 4, 5: both muted, left muted, right muted flags.
// - code 6: clock invalid on error, change or missing clocks.
// - code 7: serial audio data output stream.
// - codes 8, 9: left, right analog mute flags, low while muted.
// - codes 10 to 13: lock, charge-pump, converter, dsp clock by four.
// - codes 14, 15: under-voltage flags, 0.7 and 0.3 thresholds.
`include "amps_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module amps_top #(
  parameter int SAMPLE_W = 24,
  parameter int ZRUN_DIV = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`AMPS_ADDR_W-1:0] reg_addr,
  input wire logic [`AMPS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`AMPS_DATA_W-1:0] reg_rdata,
  input wire logic frame_clock,
  input wire logic [SAMPLE_W-1:0] left_sample,
  input wire logic [SAMPLE_W-1:0] right_sample,
  input wire amps_pkg::amps_src_type async_src,
  output logic [1:0] auto_mute,
  output logic [1:0] analog_mute,
  output logic pin2_out,
  output logic pin2_oe,
  output logic irq
);

  localparam int NSRC = $bits(amps_pkg::amps_src_type);

  amps_pkg::amps_byte_type zrun_ff;
  logic [2:0] ctl_ff;
  amps_pkg::amps_byte_type delay_ff;
  logic [3:0] sel2_ff;
  logic pin_dir_ff;
  logic pin_reg_ff;
  logic [3:0] stat_ff;
  logic [3:0] mask_ff;
  amps_pkg::amps_byte_type rdata_ff;
  logic irq_ff;
  logic pin_out_ff;
  logic pin_oe_ff;

  logic [2:0] frame_sync_ff;
  logic frame_lvl_ff;
  logic tick;

  logic [NSRC-1:0] src_s1_ff;
  logic [NSRC-1:0] src_s2_ff;
  logic [NSRC-1:0] src_s3_ff;
  logic [NSRC-1:0] src_lvl_ff;
  amps_pkg::amps_src_type src;

  logic [`AMPS_RUN_W-1:0] run_ff [2];
  logic [`AMPS_RUN_W-1:0] thr [2];
  logic [7:0] dly_ff [2];
  logic [SAMPLE_W-1:0] samp [2];
  logic [2:0] zcode [2];
  logic [1:0] en;
  logic [1:0] qual;
  logic [1:0] mute_ff;
  logic [1:0] nxt_mute;
  logic [1:0] analog_ff;
  logic joint;
  logic [3:0] events;
  logic stat_clr;
  logic nxt_pin;
  amps_pkg::amps_byte_type nxt_rdata;

  default clocking amps_cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // zero-run length in frames; fixed from the nominal 48 kHz frame rate and ZRUN_DIV
  function automatic logic [`AMPS_RUN_W-1:0] zrun_limit(
    input logic [2:0] code
  );
    int us;
    int lim;
    us = `AMPS_ZRUN_US0;
    unique case (code)
      3'h0: us = `AMPS_ZRUN_US0;
      3'h1: us = `AMPS_ZRUN_US1;
      3'h2: us = `AMPS_ZRUN_US2;
      3'h3: us = `AMPS_ZRUN_US3;
      3'h4: us = `AMPS_ZRUN_US4;
      3'h5: us = `AMPS_ZRUN_US5;
      3'h6: us = `AMPS_ZRUN_US6;
      3'h7: us = `AMPS_ZRUN_US7;
    endcase
    lim = us * `AMPS_FRAME_KHZ / 1000 / ZRUN_DIV;
    if (lim < 1) begin
      lim = 1;
    end
    return lim[`AMPS_RUN_W-1:0];
  endfunction

  // frame clock: three stages, a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_sync_ff <= 3'h0;
    end else begin
      frame_sync_ff <= {frame_sync_ff[1:0], frame_clock};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      frame_lvl_ff <= 1'b0;
    end else if (frame_sync_ff[1] == frame_sync_ff[2]) begin
      frame_lvl_ff <= frame_sync_ff[2];
    end
  end

  assign tick = (frame_sync_ff[1] == frame_sync_ff[2]) && frame_sync_ff[2]
                && !frame_lvl_ff;

  // other sources; fast clocks alias here, routing is for observation only
  for (genvar s = 0; s < NSRC; s++) begin : g_src
    always_ff @(posedge clk) begin
      if (reset) begin
        src_s1_ff[s] <= 1'b0;
        src_s2_ff[s] <= 1'b0;
        src_s3_ff[s] <= 1'b0;
        src_lvl_ff[s] <= 1'b0;
      end else begin
        src_s1_ff[s] <= async_src[s];
        src_s2_ff[s] <= src_s1_ff[s];
        src_s3_ff[s] <= src_s2_ff[s];
        if (src_s2_ff[s] == src_s3_ff[s]) begin
          src_lvl_ff[s] <= src_s3_ff[s];
        end
      end
    end
  end

  assign src = src_lvl_ff;

  assign joint = ctl_ff[`AMPS_CTL_JOINT];
  assign en[0] = ctl_ff[`AMPS_CTL_A_EN];
  assign en[1] = ctl_ff[`AMPS_CTL_B_EN];
  assign samp[0] = left_sample;
  assign samp[1] = right_sample;
  assign zcode[0] = zrun_ff[`AMPS_ZRUN_A_LSB +: 3];
  assign zcode[1] = zrun_ff[`AMPS_ZRUN_B_LSB +: 3];

  for (genvar c = 0; c < 2; c++) begin : g_chan
    assign thr[c] = zrun_limit(zcode[c]);
    assign qual[c] = en[c] && (run_ff[c] >= thr[c]);

    // saturating run of zero samples, counted once per frame
    always_ff @(posedge clk) begin
      if (reset) begin
        run_ff[c] <= '0;
      end else if (tick) begin
        if (samp[c] != '0) begin
          run_ff[c] <= '0;
        end else if (run_ff[c] < thr[c]) begin
          run_ff[c] <= run_ff[c] + 1'b1;
        end
      end
    end

    // analog mute waits the programmed frames after digital mute
    always_ff @(posedge clk) begin
      if (reset) begin
        dly_ff[c] <= 8'h00;
        analog_ff[c] <= 1'b0;
      end else if (!mute_ff[c]) begin
        dly_ff[c] <= 8'h00;
        analog_ff[c] <= 1'b0;
      end else if (!analog_ff[c]) begin
        if (dly_ff[c] >= delay_ff) begin
          analog_ff[c] <= 1'b1;
        end else if (tick) begin
          dly_ff[c] <= dly_ff[c] + 8'h01;
        end
      end
    end

    nonzero_release_a: assert property (
      tick && samp[c] != '0 |=> run_ff[c] == '0 ##1 !mute_ff[c])
      else $error("zero run not restarted by nonzero sample");

    analog_wait_a: assert property (
      $rose(analog_ff[c]) |-> $past(mute_ff[c]) && $past(dly_ff[c]) >= $past(delay_ff))
      else $error("analog mute before delay elapsed");

    analog_drop_a: assert property (
      !mute_ff[c] |=> !analog_ff[c])
      else $error("analog mute held without digital mute");
  end

  // joint mode ties both channels together, enables included
  always_comb begin
    if (joint) begin
      nxt_mute = {2{&qual}};
    end else begin
      nxt_mute = qual;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mute_ff <= 2'b00;
    end else begin
      mute_ff <= nxt_mute;
    end
  end

  indep_mute_a: assert property (
    !$past(joint) |-> mute_ff == $past(qual))
    else $error("independent mute does not follow qualification");

  joint_pair_a: assert property (
    $past(joint) |-> mute_ff[0] == mute_ff[1] && (mute_ff[0] == &$past(qual)))
    else $error("joint mute not shared");

  joint_right_off_a: assert property (
    $past(joint) && !$past(en[1]) |-> !mute_ff[0])
    else $error("left muted while right disabled in joint mode");

  joint_left_off_a: assert property (
    $past(joint) && !$past(en[0]) |-> !mute_ff[1])
    else $error("right muted while left disabled in joint mode");

  right_enable_a: assert property (
    !$past(en[1]) |-> !mute_ff[1])
    else $error("right muted while disabled");

  // pin 2 source select
  always_comb begin
    nxt_pin = 1'b0;
    unique case (sel2_ff)
      `AMPS_SEL_OFF: nxt_pin = 1'b0;
      `AMPS_SEL_DSP: nxt_pin = src.dsp_pin;
      `AMPS_SEL_REG: nxt_pin = pin_reg_ff;
      `AMPS_SEL_BOTH: nxt_pin = &mute_ff;
      `AMPS_SEL_LEFT: nxt_pin = mute_ff[0];
      `AMPS_SEL_RIGHT: nxt_pin = mute_ff[1];
      `AMPS_SEL_CLK_BAD: begin
        nxt_pin = src.clk_error | src.clk_changing | src.clk_missing;
      end
      `AMPS_SEL_SDATA: nxt_pin = src.serial_audio_out;
      `AMPS_SEL_AN_LEFT: nxt_pin = !analog_ff[0];
      `AMPS_SEL_AN_RIGHT: nxt_pin = !analog_ff[1];
      `AMPS_SEL_LOCK: nxt_pin = src.pll_lock;
      `AMPS_SEL_CP_CLK: nxt_pin = src.charge_pump_clk;
      `AMPS_SEL_DAC_CLK: nxt_pin = src.converter_clk;
      `AMPS_SEL_DSP_CLK4: nxt_pin = src.dsp_clk_div4;
      `AMPS_SEL_UV_HI: nxt_pin = src.uv_high;
      `AMPS_SEL_UV_LO: nxt_pin = src.uv_low;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      pin_out_ff <= pin_dir_ff & nxt_pin;
      pin_oe_ff <= pin_dir_ff;
    end
  end

  pin_gate_a: assert property (
    !pin_dir_ff |=> !pin_out_ff && !pin_oe_ff)
    else $error("pin driven while set as input");

  pin_reg_a: assert property (
    pin_dir_ff && sel2_ff == `AMPS_SEL_REG |=> pin_out_ff == $past(pin_reg_ff))
    else $error("register bit not on pin");

  pin_analog_a: assert property (
    pin_dir_ff && sel2_ff == `AMPS_SEL_AN_LEFT |=> pin_out_ff == !$past(analog_ff[0]))
    else $error("left analog mute flag not active low on pin");

  // register writes; unmapped offsets are ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      zrun_ff <= `AMPS_RST_ZRUN;
      ctl_ff <= `AMPS_RST_CTL;
      delay_ff <= `AMPS_RST_DELAY;
      sel2_ff <= `AMPS_RST_SEL2;
      pin_dir_ff <= 1'b0;
      pin_reg_ff <= 1'b0;
      mask_ff <= `AMPS_RST_MASK;
    end else if (reg_wr) begin
      case (reg_addr)
        `AMPS_OFF_ZRUN: zrun_ff <= reg_wdata;
        `AMPS_OFF_CTL: ctl_ff <= reg_wdata[2:0];
        `AMPS_OFF_DELAY: delay_ff <= reg_wdata;
        `AMPS_OFF_SEL2: sel2_ff <= reg_wdata[3:0];
        `AMPS_OFF_PIN_DIR: pin_dir_ff <= reg_wdata[`AMPS_PIN_BIT];
        `AMPS_OFF_PIN_REG: pin_reg_ff <= reg_wdata[`AMPS_PIN_BIT];
        `AMPS_OFF_MASK: mask_ff <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // sticky events; a new event in the clearing read survives it
  assign events = {|(mute_ff & ~nxt_mute),
                   (mute_ff[0] & !analog_ff[0] & dly_ff[0] >= delay_ff)
                     | (mute_ff[1] & !analog_ff[1] & dly_ff[1] >= delay_ff),
                   nxt_mute[1] & !mute_ff[1],
                   nxt_mute[0] & !mute_ff[0]};
  assign stat_clr = reg_rd && reg_addr == `AMPS_OFF_STAT;

  always_ff @(posedge clk) begin
    if (reset) begin
      stat_ff <= 4'h0;
    end else if (stat_clr) begin
      stat_ff <= events;
    end else begin
      stat_ff <= stat_ff | events;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      `AMPS_OFF_ZRUN: nxt_rdata = zrun_ff & 8'h77;
      `AMPS_OFF_CTL: nxt_rdata = {5'h00, ctl_ff};
      `AMPS_OFF_DELAY: nxt_rdata = delay_ff;
      `AMPS_OFF_SEL2: nxt_rdata = {4'h0, sel2_ff};
      `AMPS_OFF_PIN_DIR: nxt_rdata = {5'h00, pin_dir_ff, 2'h0};
      `AMPS_OFF_PIN_REG: nxt_rdata = {5'h00, pin_reg_ff, 2'h0};
      `AMPS_OFF_STAT: nxt_rdata = {4'h0, stat_ff};
      `AMPS_OFF_MASK: nxt_rdata = {4'h0, mask_ff};
      `AMPS_OFF_LIVE: nxt_rdata = {4'h0, analog_ff, mute_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;
  assign auto_mute = mute_ff;
  assign analog_mute = analog_ff;
  assign pin2_out = pin_out_ff;
  assign pin2_oe = pin_oe_ff;
  assign irq = irq_ff;

endmodule

`default_nettype wire

// ---- test/amps_pin_watch.sv ----
/*
 Model of the circuit outside general-purpose pin 2: a weak pull-down
 holds the wire low while the block does not drive it.
 Assumes pin2_out and pin2_oe come straight from the block.
*/
`timescale 1ns/1ns
`default_nettype none

module amps_pin_watch (
  input wire logic pin2_out,
  input wire logic pin2_oe,
  output logic level
);
  // a released pin falls to the pull-down, it never keeps the last value
  assign level = pin2_oe ? pin2_out : 1'b0;
endmodule

`default_nettype wire

// ---- test/testbench.sv ----
/*
 Self-checking bench of the auto-mute and pin 2 selector block.
 Assumes the design files under rtl/ and the pin watcher model.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end

module testbench;
  logic clk, reset, reg_wr, reg_rd, frame_clock, pin2_out, pin2_oe, irq, pin_level;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [23:0] left_sample, right_sample;
  logic [1:0] auto_mute, analog_mute;
  amps_pkg::amps_src_type async_src;
  int err_count, n_tests;
  // per case: control value, zero channels (bit0 left), expected mute
  logic [7:0] ctl_t [8] = '{8'h03, 8'h03, 8'h01, 8'h02, 8'h07, 8'h07, 8'h05, 8'h06};
  logic [1:0] zer_t [8] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h1, 2'h3, 2'h3, 2'h3};
  logic [1:0] exp_t [8] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h0, 2'h3, 2'h0, 2'h0};
  // source bit in the struct for each selector code
  int bit_t [16] = '{0, 10, 0, 0, 0, 0, 8, 9, 0, 0, 5, 4, 3, 2, 1, 0};

  amps_top #(.SAMPLE_W(24), .ZRUN_DIV(1008)) amps_top_i (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_clock(frame_clock), .left_sample(left_sample),
    .right_sample(right_sample), .async_src(async_src), .auto_mute(auto_mute),
    .analog_mute(analog_mute), .pin2_out(pin2_out), .pin2_oe(pin2_oe), .irq(irq)
  );

  amps_pin_watch amps_pin_watch_i (
    .pin2_out(pin2_out), .pin2_oe(pin2_oe), .level(pin_level)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("errors %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask

  // one frame: long enough for sync, tick and mute update to land
  task automatic frame(input logic [23:0] l, input logic [23:0] r);
    @(posedge clk);
    left_sample <= l;
    right_sample <= r;
    frame_clock <= 1'b1;
    repeat (6) @(posedge clk);
    frame_clock <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic reset_values();
    rd(8'h41);
    `CHK(rv, 8'h04)
    rd(8'h42);
    `CHK(rv, 8'h14)
    @(posedge clk);
    #1;
    `CHK(reg_rdata, 8'h00)
    rd(8'h52);
    `CHK(rv, 8'h00)
    rd(8'h3b);
    `CHK(rv, 8'h00)
    rd(8'h10);
    `CHK(rv, 8'h00)
  endtask

  task automatic mute_modes();
    wr(8'h42, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'h41, ctl_t[i]);
      frame(24'h1, 24'h1);
      `CHK(auto_mute, 2'h0)
      frame(zer_t[i][0] ? 24'h0 : 24'h5, zer_t[i][1] ? 24'h0 : 24'h5);
      `CHK(auto_mute, exp_t[i])
      `CHK(analog_mute, exp_t[i])
    end
  endtask

  // left code 1 needs a run of five zero frames at this divider
  task automatic run_length();
    wr(8'h3b, 8'h10);
    wr(8'h41, 8'h01);
    frame(24'h1, 24'h1);
    repeat (4) frame(24'h0, 24'h1);
    `CHK(auto_mute, 2'h0)
    frame(24'h0, 24'h1);
    `CHK(auto_mute, 2'h1)
    frame(24'h800000, 24'h1);
    `CHK(auto_mute, 2'h0)
    wr(8'h3b, 8'h00);
  endtask

  task automatic delay_and_irq();
    wr(8'h41, 8'h03);
    wr(8'h42, 8'h03);
    wr(8'h08, 8'h04);
    wr(8'h52, 8'h08);
    wr(8'h61, 8'h00);
    frame(24'h1, 24'h1);
    rd(8'h60);
    frame(24'h0, 24'h0);
    `CHK(auto_mute, 2'h3)
    frame(24'h0, 24'h0);
    `CHK(analog_mute, 2'h0)
    `CHK(pin_level, 1'b1)
    `CHK(irq, 1'b0)
    repeat (2) frame(24'h0, 24'h0);
    `CHK(analog_mute, 2'h3)
    `CHK(pin_level, 1'b0)
    wr(8'h61, 8'h01);
    settle();
    `CHK(irq, 1'b1)
    rd(8'h60);
    `CHK(rv[0], 1'b1)
    settle();
    `CHK(irq, 1'b0)
    frame(24'h7, 24'h7);
    `CHK(auto_mute, 2'h0)
    `CHK(analog_mute, 2'h0)
  endtask

  task automatic pin_select();
    wr(8'h08, 8'h04);
    for (int c = 0; c < 16; c++) begin
      async_src <= '0;
      wr(8'h56, 8'h00);
      wr(8'h52, 8'(c));
      settle();
      `CHK(pin2_oe, 1'b1)
      `CHK(pin_level, 1'(c == 8 || c == 9))
      if (c == 2) begin
        wr(8'h56, 8'h04);
      end else if (c >= 3 && c <= 5) begin
        frame((c == 5) ? 24'h1 : 24'h0, (c == 4) ? 24'h1 : 24'h0);
      end else if (c == 1 || c == 6 || c == 7 || c >= 10) begin
        async_src[bit_t[c]] <= 1'b1;
      end
      settle();
      `CHK(pin_level, 1'(c != 0))
      if (c >= 3 && c <= 5) begin
        frame(24'h1, 24'h1);
      end
    end
    wr(8'h08, 8'h00);
    settle();
    `CHK(pin_level, 1'b0)
    `CHK(pin2_oe, 1'b0)
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    test_done();
  end

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    frame_clock = 1'b0;
    left_sample = 24'h1;
    right_sample = 24'h1;
    async_src = '0;
    err_count = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    reset_values();
    mute_modes();
    run_length();
    delay_and_irq();
    pin_select();
    test_done();
  end
endmodule

`default_nettype wire
